/* rtl/eut_timer.sv */
// Eight-bit up-count timer with Avalon-MM register access
`timescale 1ns/10ps

// Operation
// - Eight-bit counter steps while run bit set
// - Counter write loads new start value
// - Counter read returns live count
// - Two mode bits pick count source
// - Edge bit picks falling or rising edge
// - Owner bit zero routes source through prescaler
// - Writing owner zero clears prescaler count
// - Ratio field divides by two up to 256
// - Wrap past maximum sets overflow flag
// - Flag, allow and global allow raise request
// - Flag holds until software writes zero to it or one to the clear register
module eut_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Count source pins
    input  wire logic        ext_count_input,
    input  wire logic        slow_osc_in,
    // Interrupt
    output logic             irq
);

    // ==========================================
    // Registers
    logic [7:0]         power_control_one; // Run and global allow
    logic [7:0]         count;             // Live counter
    eut_pkg::eut_mode_t counter_mode_reg;  // Source and prescaler
    logic               overflow_flag;     // Sticky overflow
    logic               overflow_irq_allow; // Overflow enable

    // ==========================================
    // Bus decode
    wire       req;       // Any request
    wire       accept;    // Request completes this edge
    wire       wr_ok;     // Write takes effect
    wire       rd_cap;    // Read data captured
    wire       wr_pwr;    // Write power control
    wire       wr_cnt;    // Write counter
    wire       wr_mode;   // Write mode
    wire       wr_flag;   // Write flag register
    wire       wr_ien;    // Write enable register
    wire       wr_iclr;   // Write clear register
    wire [7:0] wbyte;     // Low write byte
    logic [7:0] rd_mux;   // Selected read value

    assign req     = avs_read | avs_write;
    assign accept  = req & ~avs_waitrequest;
    assign rd_cap  = avs_read & avs_waitrequest;
    assign wr_ok   = avs_write & ~avs_waitrequest;
    assign wbyte   = avs_writedata[7:0];
    assign wr_pwr  = wr_ok && (avs_address == eut_pkg::OFS_PWR);
    assign wr_cnt  = wr_ok && (avs_address == eut_pkg::OFS_CNT);
    assign wr_mode = wr_ok && (avs_address == eut_pkg::OFS_MODE);
    assign wr_flag = wr_ok && (avs_address == eut_pkg::OFS_FLAG);
    assign wr_ien  = wr_ok && (avs_address == eut_pkg::OFS_IEN);
    assign wr_iclr = wr_ok && (avs_address == eut_pkg::OFS_ICLR);

    // ==========================================
    // Count path
    wire        run;        // Counter run bit
    wire        global_irq_allow;        // Global interrupt allow
    wire        src_ev;     // Selected source event
    wire        tick;       // Counter step
    wire        wrap;       // Overflow this cycle
    wire        presc_clr;  // Prescaler clear
    wire [7:0]  pcount;     // Prescaler count
    wire [7:0]  next_count; // Next counter value
    wire        flag_clr;   // Software clears flag
    wire        next_flag;  // Next flag value
    eut_pkg::eut_mode_t wmode; // Mode as written

    assign run  = power_control_one[eut_pkg::BIT_RUN];
    assign global_irq_allow  = power_control_one[eut_pkg::BIT_GIE];
    assign wmode = eut_pkg::eut_mode_t'(wbyte);

    // Source select and edge detect
    eut_edge_pick u_edge (
        .clk             (clk),
        .srst            (srst),
        .mode            (counter_mode_reg),
        .ext_count_input (ext_count_input),
        .slow_osc_in     (slow_osc_in),
        .src_event       (src_ev)
    );

    // Clear when an instruction writes owner zero
    assign presc_clr = wr_mode && !wmode.prescale_owner_bit;

    // Prescaler, only fed while running
    eut_prescale u_presc (
        .clk       (clk),
        .srst      (srst),
        .owner_wdt (counter_mode_reg.prescale_owner_bit),
        .ratio     (counter_mode_reg.prescale_ratio_field),
        .clr       (presc_clr),
        .ev_in     (src_ev & run),
        .ev_out    (tick),
        .pcount    (pcount)
    );

    // Load wins over step
    assign wrap = run && tick && !wr_cnt && (count == eut_pkg::CNT_MAX);
    assign next_count = wr_cnt ? wbyte :
                        (run && tick) ? count + 8'h01 :
                        count;

    // Zero write to flag register or one to clear register
    assign flag_clr = (wr_flag && !wbyte[eut_pkg::BIT_OVF]) ||
                      (wr_iclr && wbyte[eut_pkg::BIT_OVF]);
    // Set wins over clear
    assign next_flag = wrap ? 1'b1 :
                       flag_clr ? 1'b0 : overflow_flag;

    // ==========================================
    // Read selection
    always_comb begin
        case (avs_address)
            eut_pkg::OFS_PWR:  rd_mux = power_control_one;
            eut_pkg::OFS_CNT:  rd_mux = count;
            eut_pkg::OFS_MODE: rd_mux = counter_mode_reg;
            eut_pkg::OFS_FLAG: rd_mux = {7'h00, overflow_flag};
            eut_pkg::OFS_IEN:  rd_mux = {7'h00, overflow_irq_allow};
            eut_pkg::OFS_PSCV: rd_mux = pcount;
            default:           rd_mux = 8'h00;
        endcase
    end

    // ==========================================
    // Bus handshake: one wait cycle per access
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
        end
    end

    // Read data latched at the first request edge
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_cap) begin
            avs_readdata <= {24'h00_0000, rd_mux};
        end
    end

    // ==========================================
    // Control registers
    always_ff @(posedge clk) begin
        if (srst) begin
            power_control_one  <= eut_pkg::RST_PWR;
            counter_mode_reg   <= eut_pkg::eut_mode_t'(eut_pkg::RST_MODE);
            overflow_irq_allow <= 1'b0;
        end else begin
            if (wr_pwr) begin
                power_control_one <= wbyte;
            end
            if (wr_mode) begin
                counter_mode_reg <= wmode;
            end
            if (wr_ien) begin
                overflow_irq_allow <= wbyte[eut_pkg::BIT_OVF];
            end
        end
    end

    // Counter and flag
    always_ff @(posedge clk) begin
        if (srst) begin
            count         <= 8'h00;
            overflow_flag <= 1'b0;
        end else begin
            count         <= next_count;
            overflow_flag <= next_flag;
        end
    end

    // Interrupt request, registered
    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_flag & overflow_irq_allow & global_irq_allow;
        end
    end

    // ==========================================
    // Checks
    sequence s_cnt_write;
        wr_cnt;
    endsequence

    sequence s_wrap_step;
        run && tick && !wr_cnt && count == eut_pkg::CNT_MAX;
    endsequence

    // Counter step that went through the prescaler
    sequence s_prescaled_tick;
        !counter_mode_reg.prescale_owner_bit && tick;
    endsequence

    // Software clear that no wrap overrides
    sequence s_flag_clear;
        flag_clr && !wrap;
    endsequence

    // Mode write that hands the prescaler to the counter
    sequence s_owner_grab;
        wr_mode && !wmode.prescale_owner_bit;
    endsequence

    a_run_gate: assert property (@(posedge clk) disable iff (srst)
        (!run && !wr_cnt) |=> count == $past(count))
        else $error("counter moved while stopped");

    a_count_step: assert property (@(posedge clk) disable iff (srst)
        (run && tick && !wr_cnt) |=> count == $past(count) + 8'h01)
        else $error("counter did not step by one");

    a_load_value: assert property (@(posedge clk) disable iff (srst)
        s_cnt_write |=> count == $past(wbyte))
        else $error("counter write not loaded");

    a_read_live: assert property (@(posedge clk) disable iff (srst)
        (rd_cap && avs_address == eut_pkg::OFS_CNT)
        |=> !avs_waitrequest && avs_readdata[7:0] == $past(count))
        else $error("counter read not live");

    a_src_clock: assert property (@(posedge clk) disable iff (srst)
        (run && !counter_mode_reg.count_source_select
         && counter_mode_reg.prescale_owner_bit && !wr_cnt)
        |=> count == $past(count) + 8'h01)
        else $error("instruction clock not counted");

    a_flag_set: assert property (@(posedge clk) disable iff (srst)
        s_wrap_step |=> overflow_flag && count == 8'h00)
        else $error("overflow flag not set");

    a_flag_hold: assert property (@(posedge clk) disable iff (srst)
        (overflow_flag && !flag_clr) |=> overflow_flag)
        else $error("overflow flag dropped");

    a_irq_raise: assert property (@(posedge clk) disable iff (srst)
        (overflow_flag && !flag_clr && overflow_irq_allow && global_irq_allow) |=> irq)
        else $error("interrupt not raised");

    a_irq_quiet: assert property (@(posedge clk) disable iff (srst)
        !global_irq_allow [*2] |-> !irq)
        else $error("interrupt without global allow");

    a_bus_answer: assert property (@(posedge clk) disable iff (srst)
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer late");

    // A completed access closes its wait window
    a_bus_close: assert property (@(posedge clk) disable iff (srst)
        accept |=> avs_waitrequest)
        else $error("waitrequest stayed low after completion");

    // Idle bus keeps the slave stalled
    a_bus_idle: assert property (@(posedge clk) disable iff (srst)
        !req |=> avs_waitrequest)
        else $error("waitrequest low with no request");

    // No step at all while the run bit is clear
    a_stop_quiet: assert property (@(posedge clk) disable iff (srst)
        !run |-> !tick)
        else $error("counter step while stopped");

    // Divided steps only on a source event at terminal count
    a_div_gate: assert property (@(posedge clk) disable iff (srst)
        s_prescaled_tick |-> src_ev
            && pcount == eut_pkg::ratio_mask(counter_mode_reg.prescale_ratio_field))
        else $error("prescaled step off terminal count");

    // Owner-zero write leaves the prescaler empty
    a_owner_clear: assert property (@(posedge clk) disable iff (srst)
        s_owner_grab |=> pcount == 8'h00)
        else $error("prescaler not emptied on owner write");

    // Watchdog-owned prescaler passes every event
    a_direct_step: assert property (@(posedge clk) disable iff (srst)
        (counter_mode_reg.prescale_owner_bit && run && src_ev) |-> tick)
        else $error("undivided source event dropped");

    // Software clear drops the flag
    a_flag_clear: assert property (@(posedge clk) disable iff (srst)
        s_flag_clear |=> !overflow_flag)
        else $error("overflow flag not cleared");

    // Flag rises only from a wrap
    a_flag_cause: assert property (@(posedge clk) disable iff (srst)
        (!overflow_flag && !wrap) |=> !overflow_flag)
        else $error("overflow flag set without wrap");

    // Masked overflow never requests
    a_irq_mask: assert property (@(posedge clk) disable iff (srst)
        !overflow_irq_allow |=> !irq)
        else $error("interrupt while overflow masked");

    // Mode write lands as written
    a_mode_load: assert property (@(posedge clk) disable iff (srst)
        wr_mode |=> counter_mode_reg == $past(wmode))
        else $error("mode write not stored");

endmodule : eut_timer

/* rtl/eut_pkg.sv */
// Package: register map, field layout and shared types of the timer
package eut_pkg;

    // ==========================================
    // Register byte offsets
    localparam logic [5:0] OFS_PWR   = 6'h00; // Power control one
    localparam logic [5:0] OFS_CNT   = 6'h04; // Live counter
    localparam logic [5:0] OFS_MODE  = 6'h08; // Counter mode
    localparam logic [5:0] OFS_FLAG  = 6'h0C; // Interrupt flags
    localparam logic [5:0] OFS_IEN   = 6'h10; // Interrupt enables
    localparam logic [5:0] OFS_ICLR  = 6'h14; // Flag clear, write-only
    localparam logic [5:0] OFS_PSCV  = 6'h18; // Prescaler count

    // ==========================================
    // Field positions
    localparam int BIT_RUN  = 0;  // Counter run bit
    localparam int BIT_GIE  = 7;  // Global interrupt allow
    localparam int BIT_OVF  = 0;  // Overflow flag / allow

    // ==========================================
    // Reset values and limits
    localparam logic [7:0] RST_PWR  = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h08; // Prescaler owned by watchdog
    localparam logic [7:0] CNT_MAX  = 8'hFF;

    // Counter mode register layout
    typedef struct packed {
        logic       slow_osc_route;       // Route slow oscillator
        logic       rsvd;                 // Reads back as stored
        logic       count_source_select;  // 0 = instruction clock
        logic       edge_polarity_select; // 1 = falling edge
        logic       prescale_owner_bit;   // 1 = watchdog owns prescaler
        logic [2:0] prescale_ratio_field; // Ratio code
    } eut_mode_t;

    // Terminal prescaler count for a ratio code: 2^(n+1)-1
    function automatic logic [7:0] ratio_mask(input logic [2:0] code);
        ratio_mask = 8'hFF >> (3'h7 - code);
    endfunction : ratio_mask

endpackage : eut_pkg

/* rtl/eut_edge_pick.sv */
// Count source selection and active-edge detection
`timescale 1ns/10ps
module eut_edge_pick (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            srst,
    // Mode
    input  wire eut_pkg::eut_mode_t mode,
    // Source pins
    input  wire logic            ext_count_input,
    input  wire logic            slow_osc_in,
    // Selected source event
    output logic                 src_event
);

    // ==========================================
    // Previous levels of the pin sources
    logic ext_prev;  // Last pin level
    logic slow_prev; // Last oscillator level
    wire  cur_lvl;   // Selected level now
    wire  old_lvl;   // Selected level before
    wire  rise;      // Low to high
    wire  fall;      // High to low

    // Keep the last level of each source
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_prev  <= 1'b0;
            slow_prev <= 1'b0;
        end else begin
            ext_prev  <= ext_count_input;
            slow_prev <= slow_osc_in;
        end
    end

    // Pin or slow oscillator
    assign cur_lvl = mode.slow_osc_route ? slow_osc_in : ext_count_input;
    assign old_lvl = mode.slow_osc_route ? slow_prev : ext_prev;
    assign rise    = ~old_lvl & cur_lvl;
    assign fall    = old_lvl & ~cur_lvl;

    // Instruction clock counts every cycle
    assign src_event = ~mode.count_source_select ? 1'b1 :
                       (mode.edge_polarity_select ? fall : rise);

    // ==========================================
    // Checks
    a_edge_fall: assert property (@(posedge clk) disable iff (srst)
        (mode.count_source_select && mode.edge_polarity_select && rise)
        |-> !src_event)
        else $error("rising edge counted in falling mode");

endmodule : eut_edge_pick

/* rtl/eut_prescale.sv */
// Shared power-of-two prescaler
`timescale 1ns/10ps
module eut_prescale (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Control
    input  wire logic       owner_wdt,
    input  wire logic [2:0] ratio,
    input  wire logic       clr,
    // Events
    input  wire logic       ev_in,
    output logic            ev_out,
    // Status
    output logic [7:0]      pcount
);

    // ==========================================
    wire       at_end;     // Terminal count reached
    wire [7:0] next_count; // Next prescaler count

    assign at_end = (pcount == eut_pkg::ratio_mask(ratio));

    // Clear wins, else step while owned by counter
    assign next_count = clr ? 8'h00 :
                        (ev_in && !owner_wdt) ?
                        (at_end ? 8'h00 : pcount + 8'h01) : pcount;

    // Divided or direct event
    assign ev_out = owner_wdt ? ev_in :
                    (ev_in && at_end && !clr);

    // Prescaler count register
    always_ff @(posedge clk) begin
        if (srst) begin
            pcount <= 8'h00;
        end else begin
            pcount <= next_count;
        end
    end

    // ==========================================
    // Checks
    a_presc_clear: assert property (@(posedge clk) disable iff (srst)
        clr |=> pcount == 8'h00)
        else $error("prescaler not cleared");

    a_presc_ratio: assert property (@(posedge clk) disable iff (srst)
        (ev_out && !owner_wdt) |-> pcount == eut_pkg::ratio_mask(ratio))
        else $error("prescaler tick at wrong count");

endmodule : eut_prescale

/* tb/eight_bit_upcount_timer_tb_top.sv */
// Testbench: register-level self-checking tests of the eight-bit up-count timer
`timescale 1ns/10ps
module eight_bit_upcount_timer_tb_top;

    // ==========================================
    // Signals
    logic        clk;              // Bus clock
    logic        srst;             // Synchronous reset
    logic [5:0]  avs_address;      // Register address
    logic        avs_read;         // Read strobe
    logic        avs_write;        // Write strobe
    logic [31:0] avs_writedata;    // Write data
    logic [31:0] avs_readdata;     // Read data
    logic        avs_waitrequest;  // Slave stall
    logic        ext_count_input;  // External count pin
    logic        slow_osc_in;      // Slow oscillator level
    logic        irq;              // Interrupt request
    int          n_fail;           // Mismatch count
    int          compares;         // Comparison count
    logic [7:0]  rd_a;             // First read value
    logic [7:0]  rd_b;             // Second read value
    logic [7:0]  mode_tab [4];     // Source and edge modes
    logic [7:0]  exp_tab [4];      // Expected counts per mode

    // ==========================================
    // Device under test
    eut_timer dut (
        .clk             (clk),
        .srst            (srst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .ext_count_input (ext_count_input),
        .slow_osc_in     (slow_osc_in),
        .irq             (irq)
    );

    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================
    // Tasks
    // Compare one byte and count the result
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Hold until waitrequest is sampled low at a rising edge, take data there
    // A hung slave is ended by the watchdog, not here
    task bus_wait(output logic [7:0] d);
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        d = avs_readdata[7:0];
    endtask : bus_wait

    // Register write
    task bus_wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] junk;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_write     <= 1'b1;
        bus_wait(junk);
        avs_write     <= 1'b0;
    endtask : bus_wr

    // Register read
    task bus_rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        bus_wait(d);
        avs_read    <= 1'b0;
    endtask : bus_rd

    // Read and compare
    task rd_chk(input logic [5:0] a, input logic [7:0] exp, input string name);
        bus_rd(a, rd_a);
        check(name, rd_a, exp);
    endtask : rd_chk

    // Interrupt level once the registered output has settled
    task chk_irq(input logic exp);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("irq", {7'h00, irq}, {7'h00, exp});
    endtask : chk_irq

    // Print counts and verdict, end the run
    task stop_test;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    // ==========================================
    // Test sequence
    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        ext_count_input = 1'b0;
        slow_osc_in = 1'b0;
        n_fail = 0;
        compares = 0;
        mode_tab = '{8'h28, 8'h38, 8'hA8, 8'hB8};
        exp_tab = '{8'h04, 8'h03, 8'h02, 8'h01};
        srst = 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        // Reset values, unmapped and write-only places read zero
        rd_chk(eut_pkg::OFS_PWR, eut_pkg::RST_PWR, "pwr");
        rd_chk(eut_pkg::OFS_CNT, 8'h00, "cnt");
        rd_chk(eut_pkg::OFS_MODE, eut_pkg::RST_MODE, "mode");
        rd_chk(eut_pkg::OFS_FLAG, 8'h00, "flag");
        rd_chk(eut_pkg::OFS_IEN, 8'h00, "ien");
        rd_chk(eut_pkg::OFS_ICLR, 8'h00, "iclr");
        rd_chk(eut_pkg::OFS_PSCV, 8'h00, "pscv");
        rd_chk(6'h1C, 8'h00, "unmapped");
        // Load while stopped: value holds
        bus_wr(eut_pkg::OFS_CNT, 8'h5A);
        repeat (5) @(posedge clk);
        rd_chk(eut_pkg::OFS_CNT, 8'h5A, "cnt_hold");
        // Undivided instruction clock: reads seven cycles apart
        bus_wr(eut_pkg::OFS_PWR, 8'h01);
        bus_rd(eut_pkg::OFS_CNT, rd_a);
        repeat (4) @(posedge clk);
        bus_rd(eut_pkg::OFS_CNT, rd_b);
        check("cnt_step", rd_b - rd_a, 8'h07);
        // Every ratio code: reads two prescaler periods apart
        for (int n = 0; n < 8; n++) begin
            bus_wr(eut_pkg::OFS_MODE, {5'b00000, n[2:0]});
            bus_rd(eut_pkg::OFS_CNT, rd_a);
            repeat ((4 << n) - 3) @(posedge clk);
            bus_rd(eut_pkg::OFS_CNT, rd_b);
            check("cnt_div", rd_b - rd_a, 8'h02);
        end
        // Owner-zero write clears the prescaler count
        bus_wr(eut_pkg::OFS_MODE, 8'h07);
        repeat (10) @(posedge clk);
        bus_wr(eut_pkg::OFS_PWR, 8'h00);
        bus_rd(eut_pkg::OFS_PSCV, rd_a);
        check("psc_live", {7'h00, rd_a != 8'h00}, 8'h01);
        bus_wr(eut_pkg::OFS_MODE, 8'h07);
        rd_chk(eut_pkg::OFS_PSCV, 8'h00, "psc_clr");
        // Overflow flag and interrupt gating
        bus_wr(eut_pkg::OFS_MODE, 8'h08);
        bus_wr(eut_pkg::OFS_CNT, 8'hFE);
        bus_wr(eut_pkg::OFS_IEN, 8'h01);
        bus_wr(eut_pkg::OFS_PWR, 8'h80);
        chk_irq(1'b0);
        bus_wr(eut_pkg::OFS_PWR, 8'h81);
        bus_wr(eut_pkg::OFS_PWR, 8'h80);
        rd_chk(eut_pkg::OFS_FLAG, 8'h01, "flag_set");
        chk_irq(1'b1);
        bus_wr(eut_pkg::OFS_IEN, 8'h00);
        chk_irq(1'b0);
        bus_wr(eut_pkg::OFS_IEN, 8'h01);
        chk_irq(1'b1);
        bus_wr(eut_pkg::OFS_PWR, 8'h00);
        chk_irq(1'b0);
        bus_wr(eut_pkg::OFS_PWR, 8'h80);
        // Writing one leaves the flag; writing zero clears it
        bus_wr(eut_pkg::OFS_FLAG, 8'h01);
        repeat (20) @(posedge clk);
        rd_chk(eut_pkg::OFS_FLAG, 8'h01, "flag_stick");
        bus_wr(eut_pkg::OFS_FLAG, 8'h00);
        rd_chk(eut_pkg::OFS_FLAG, 8'h00, "flag_clr");
        chk_irq(1'b0);
        // Second wrap, cleared through the clear register
        bus_wr(eut_pkg::OFS_CNT, 8'hFF);
        bus_wr(eut_pkg::OFS_PWR, 8'h81);
        bus_wr(eut_pkg::OFS_PWR, 8'h80);
        rd_chk(eut_pkg::OFS_FLAG, 8'h01, "flag_set2");
        bus_wr(eut_pkg::OFS_ICLR, 8'h01);
        rd_chk(eut_pkg::OFS_FLAG, 8'h00, "flag_iclr");
        // Pin and oscillator sources, both edges
        for (int k = 0; k < 4; k++) begin
            bus_wr(eut_pkg::OFS_MODE, mode_tab[k]);
            bus_wr(eut_pkg::OFS_CNT, 8'h00);
            bus_wr(eut_pkg::OFS_PWR, 8'h01);
            for (int i = 0; i < 7; i++) begin
                @(posedge clk);
                ext_count_input <= ~ext_count_input;
                if (i < 6 && i % 2 == 0)
                    slow_osc_in <= ~slow_osc_in;
                @(posedge clk);
            end
            repeat (3) @(posedge clk);
            bus_wr(eut_pkg::OFS_PWR, 8'h00);
            rd_chk(eut_pkg::OFS_CNT, exp_tab[k], "cnt_src");
            @(posedge clk);
            ext_count_input <= 1'b0;
            slow_osc_in     <= 1'b0;
            repeat (2) @(posedge clk);
        end
        // Slow oscillator through the prescaler at one-in-eight
        bus_wr(eut_pkg::OFS_MODE, 8'hA2);
        bus_wr(eut_pkg::OFS_CNT, 8'h00);
        bus_wr(eut_pkg::OFS_PWR, 8'h01);
        repeat (32) begin
            @(posedge clk);
            slow_osc_in <= ~slow_osc_in;
            @(posedge clk);
        end
        bus_wr(eut_pkg::OFS_PWR, 8'h00);
        rd_chk(eut_pkg::OFS_CNT, 8'h02, "cnt_slow");
        rd_chk(eut_pkg::OFS_PSCV, 8'h00, "psc_slow");
        stop_test();
    end

endmodule : eight_bit_upcount_timer_tb_top
